// ===== design/css_consts.vh
// Constants for the configuration start-up sequencer
`ifndef CSS_CONSTS_VH
`define CSS_CONSTS_VH
// Master wait after init goes high, in us, and core clock rate in MHz
`define CSS_INIT_WAIT_US      300
`define CSS_CLK_MHZ           100
`define CSS_INIT_WAIT_CYC     (`CSS_INIT_WAIT_US * `CSS_CLK_MHZ)
// Start-up timing option codes (I_SU_OPTION)
`define CSS_OPT_OSC_FREE      2'h0
`define CSS_OPT_OSC_SYNC      2'h1
`define CSS_OPT_USR_FREE      2'h2
`define CSS_OPT_USR_SYNC      2'h3
// Option field positions: bit 1 selects user clock, bit 0 completion sync
`define CSS_OPT_USR_BIT       1
`define CSS_OPT_SYNC_BIT      0
// Default event steps: completion pin, output float, set/reset
`define CSS_STEP_DONE_DEF     2'h1
`define CSS_STEP_FLOAT_DEF    2'h2
`define CSS_STEP_GSR_DEF      2'h3
// Last start-up step number
`define CSS_STEP_LAST         3'h4
`endif

// ===== design/css_edge_sync.v
// Three-stage synchroniser with rising-edge output for one asynchronous input
`timescale 1ns/100ps
module css_edge_sync (
  input  wire I_CORE_CLK,
  input  wire I_RST_B,
  input  wire I_ASYNC,
  output reg  O_LEVEL,
  output wire O_RISE
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // ****************************************
  // Synchroniser chain
  // ****************************************
  // Level updates only when stages two and three agree
  always @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      O_LEVEL <= 1'b0;
    end else begin
      s1_q <= I_ASYNC;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        O_LEVEL <= s3_q;
      end
    end
  end
  assign O_RISE = I_RST_B & (s2_q == s3_q) & s3_q & ~O_LEVEL;
endmodule // css_edge_sync

// ===== design/css_startup.v
// Configuration start-up sequencer: mode capture, start gate, event ordering
`timescale 1ns/100ps
`include "css_consts.vh"
// Overview of operation
// - After init release, capture mode, then accept data
// - Master waits extra 300 us after init high
// - Start needs full memory and, unless express, exact length match
// - Non-express: store length count, count config clocks
// - Express: start once own data share received
// - Shared completion net holds all until everyone done; here only sync options wait on it
// - Unconnected completion pin: start when self configured
// - Sequence completion pin, output float, set/reset
// - Any event ordering selectable by options
// - Advance only on start-up clock until finished
// - Default: completion, outputs next clock, set/reset after
// - Clock by oscillator, or optionally user net
// - Completion pin open-drain low only, pull-up default
// - Sync options read completion pin, others ignore it
// - Express forces a completion-synchronous option
// - User-sync option stalls while pin held low
// - Set/reset drives flops to local set/reset state
// - Output float tri-states outputs except during EXTEST
module css_startup #(
  parameter                 INIT_WAIT_CYC = `CSS_INIT_WAIT_CYC,
  parameter                 LEN_W         = 24
) (
  input  wire               I_CORE_CLK,
  input  wire               I_RST_B,
  input  wire               I_INIT_B,
  input  wire [2:0]         I_MODE_PINS,
  input  wire               I_MASTER,
  input  wire               I_EXPRESS,
  input  wire               I_CFG_CLK_PULSE,
  input  wire               I_LEN_LOAD,
  input  wire [LEN_W-1:0]   I_LEN_VALUE,
  input  wire               I_MEM_FULL,
  input  wire               I_QUOTA_DONE,
  input  wire [1:0]         I_SU_OPTION,
  input  wire               I_PULLUP_DIS,
  input  wire [1:0]         I_STEP_DONE,
  input  wire [1:0]         I_STEP_FLOAT,
  input  wire [1:0]         I_STEP_GSR,
  input  wire               I_CONFIG_OSC_CLOCK,
  input  wire               I_USER_STARTUP_CLOCK,
  input  wire               I_DONE_PIN,
  input  wire               I_EXTEST,
  input  wire               I_LOCAL_SET_RESET,
  input  wire               I_FF_IS_SET,
  output reg  [2:0]         O_MODE,
  output reg                O_CFG_READY,
  output wire               O_DONE_OUT,
  output reg                O_DONE_OE_B,
  output reg                O_DONE_PULLUP,
  output reg                O_GLOBAL_OUTPUT_FLOAT,
  output reg                O_GLOBAL_SET_RESET,
  output reg                O_FF_FORCE,
  output reg                O_FF_VALUE,
  output reg                O_IO_HIZ,
  output reg                O_FINISHED,
  output reg  [2:0]         O_STEP
);
  // ****************************************
  // States
  // ****************************************
  localparam [2:0] ST_CLEAR  = 3'h0;
  localparam [2:0] ST_WAIT   = 3'h1;
  localparam [2:0] ST_LOAD   = 3'h2;
  localparam [2:0] ST_SEQ    = 3'h3;
  localparam [2:0] ST_FINISH = 3'h4;

  reg  [2:0]       state_q;
  reg  [2:0]       state_d;
  reg  [31:0]      wait_q;
  reg  [LEN_W-1:0] len_q;
  reg  [LEN_W-1:0] cnt_q;
  reg  [1:0]       opt_q;
  reg  [2:0]       step_q;
  reg              done_oe_b_d;
  reg              float_d;
  reg              gsr_d;
  wire [2:0]       mode_lvl;
  wire             init_hi;
  wire             init_rise;
  wire             osc_lvl;
  wire             osc_rise;
  wire             usr_lvl;
  wire             usr_rise;
  wire             done_lvl;
  wire             su_tick;
  wire             use_sync;
  wire             start_ok;
  wire             stall;

  // Released when the current step has reached the programmed step
  function released;
    input [2:0] step;
    input [1:0] at;
    begin
      released = (step >= {1'b0, at});
    end
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  css_edge_sync u_init_sync (
    .I_CORE_CLK (I_CORE_CLK),
    .I_RST_B    (I_RST_B),
    .I_ASYNC    (I_INIT_B),
    .O_LEVEL    (init_hi),
    .O_RISE     (init_rise)
  );
  css_edge_sync u_osc_sync (
    .I_CORE_CLK (I_CORE_CLK),
    .I_RST_B    (I_RST_B),
    .I_ASYNC    (I_CONFIG_OSC_CLOCK),
    .O_LEVEL    (osc_lvl),
    .O_RISE     (osc_rise)
  );
  css_edge_sync u_usr_sync (
    .I_CORE_CLK (I_CORE_CLK),
    .I_RST_B    (I_RST_B),
    .I_ASYNC    (I_USER_STARTUP_CLOCK),
    .O_LEVEL    (usr_lvl),
    .O_RISE     (usr_rise)
  );
  css_edge_sync u_done_sync (
    .I_CORE_CLK (I_CORE_CLK),
    .I_RST_B    (I_RST_B),
    .I_ASYNC    (I_DONE_PIN),
    .O_LEVEL    (done_lvl),
    .O_RISE     ()
  );
  // Mode pins are static well before init rises, so a bitwise
  // sync cannot capture a torn mode
  css_edge_sync u_mode0_sync (
    .I_CORE_CLK (I_CORE_CLK),
    .I_RST_B    (I_RST_B),
    .I_ASYNC    (I_MODE_PINS[0]),
    .O_LEVEL    (mode_lvl[0]),
    .O_RISE     ()
  );
  css_edge_sync u_mode1_sync (
    .I_CORE_CLK (I_CORE_CLK),
    .I_RST_B    (I_RST_B),
    .I_ASYNC    (I_MODE_PINS[1]),
    .O_LEVEL    (mode_lvl[1]),
    .O_RISE     ()
  );
  css_edge_sync u_mode2_sync (
    .I_CORE_CLK (I_CORE_CLK),
    .I_RST_B    (I_RST_B),
    .I_ASYNC    (I_MODE_PINS[2]),
    .O_LEVEL    (mode_lvl[2]),
    .O_RISE     ()
  );

  // ****************************************
  // Start-up clock and gating
  // ****************************************
  // Start-up clock is seen as a rising-edge tick; core clock must be
  // well above four times the start-up clock rate for no edge to be missed
  assign su_tick  = opt_q[`CSS_OPT_USR_BIT] ? usr_rise : osc_rise;
  assign use_sync = opt_q[`CSS_OPT_SYNC_BIT];
  // Pin is only looked at once our own driver has let go; a floating
  // pin reads high through the pull-up, so a lone device proceeds
  assign stall    = use_sync & released(step_q, I_STEP_DONE) & ~done_lvl;
  assign start_ok = I_MEM_FULL &
                    (I_EXPRESS ? I_QUOTA_DONE : (cnt_q == len_q));

  // ****************************************
  // Sequencer
  // ****************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_CLEAR: begin
        if (init_rise) begin
          state_d = I_MASTER ? ST_WAIT : ST_LOAD;
        end
      end
      ST_WAIT: begin
        if (wait_q >= INIT_WAIT_CYC - 1) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (start_ok) begin
          state_d = ST_SEQ;
        end
      end
      ST_SEQ: begin
        if (su_tick && !stall && step_q == `CSS_STEP_LAST - 3'h1) begin
          state_d = ST_FINISH;
        end
      end
      ST_FINISH: state_d = ST_FINISH;
      default:   state_d = ST_CLEAR;
    endcase
  end

  always @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      state_q     <= ST_CLEAR;
      wait_q      <= 32'h0;
      len_q       <= {LEN_W{1'b0}};
      cnt_q       <= {LEN_W{1'b0}};
      opt_q       <= `CSS_OPT_OSC_FREE;
      step_q      <= 3'h0;
      O_MODE      <= 3'h0;
      O_CFG_READY <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_CLEAR && init_rise) begin
        O_MODE <= mode_lvl;
        cnt_q  <= {LEN_W{1'b0}};
        wait_q <= 32'h0;
      end
      if (state_q == ST_WAIT) begin
        wait_q <= wait_q + 32'h1;
      end
      O_CFG_READY <= (state_d == ST_LOAD);
      if (state_q == ST_LOAD) begin
        if (I_LEN_LOAD && !I_EXPRESS) begin
          len_q <= I_LEN_VALUE;
        end
        if (I_CFG_CLK_PULSE && !I_EXPRESS) begin
          cnt_q <= cnt_q + {{(LEN_W-1){1'b0}}, 1'b1};
        end
        if (start_ok) begin
          // Express may not run free of the completion pin
          opt_q <= I_EXPRESS ? (I_SU_OPTION | `CSS_OPT_OSC_SYNC) : I_SU_OPTION;
          step_q <= 3'h0;
        end
      end
      if (state_q == ST_SEQ && su_tick && !stall) begin
        step_q <= step_q + 3'h1;
      end
    end
  end

  // ****************************************
  // Event next values
  // ****************************************
  // Steps are zero for "never held"; defaults give completion, float,
  // then set/reset one start-up clock apart
  always @* begin
    done_oe_b_d = 1'b0;
    float_d     = 1'b1;
    gsr_d       = 1'b1;
    case (state_q)
      ST_SEQ: begin
        done_oe_b_d = released(step_q, I_STEP_DONE);
        float_d     = ~released(step_q, I_STEP_FLOAT);
        gsr_d       = ~released(step_q, I_STEP_GSR);
      end
      ST_FINISH: begin
        done_oe_b_d = 1'b1;
        float_d     = 1'b0;
        gsr_d       = 1'b0;
      end
      default: begin
        done_oe_b_d = 1'b0;
        float_d     = 1'b1;
        gsr_d       = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Event outputs
  // ****************************************
  always @(posedge I_CORE_CLK) begin
    if (!I_RST_B) begin
      O_DONE_OE_B           <= 1'b0;
      O_DONE_PULLUP         <= 1'b1;
      O_GLOBAL_OUTPUT_FLOAT <= 1'b1;
      O_GLOBAL_SET_RESET    <= 1'b1;
      O_FF_FORCE            <= 1'b1;
      O_FF_VALUE            <= 1'b0;
      O_IO_HIZ              <= 1'b1;
      O_FINISHED            <= 1'b0;
      O_STEP                <= 3'h0;
    end else begin
      O_DONE_PULLUP <= ~I_PULLUP_DIS;
      O_STEP        <= step_q;
      O_FINISHED    <= (state_q == ST_FINISH);
      O_DONE_OE_B           <= done_oe_b_d;
      O_GLOBAL_OUTPUT_FLOAT <= float_d;
      O_GLOBAL_SET_RESET    <= gsr_d;
      O_FF_FORCE <= O_GLOBAL_SET_RESET | I_LOCAL_SET_RESET;
      O_FF_VALUE <= I_FF_IS_SET;
      O_IO_HIZ   <= O_GLOBAL_OUTPUT_FLOAT & ~I_EXTEST;
    end
  end

  // Open-drain completion pin only ever drives low
  assign O_DONE_OUT = 1'b0;
endmodule // css_startup

// ===== tb/css_startup_chk.sv
// Port assertions for the start-up sequencer
`timescale 1ns/100ps
module css_startup_chk (
  input wire       I_CORE_CLK,
  input wire       I_RST_B,
  input wire       I_INIT_B,
  input wire       I_MASTER,
  input wire       I_EXPRESS,
  input wire       I_MEM_FULL,
  input wire       I_QUOTA_DONE,
  input wire [1:0] I_SU_OPTION,
  input wire [1:0] I_STEP_DONE,
  input wire [1:0] I_STEP_FLOAT,
  input wire [1:0] I_STEP_GSR,
  input wire       I_DONE_PIN,
  input wire       I_PULLUP_DIS,
  input wire       I_EXTEST,
  input wire       I_LOCAL_SET_RESET,
  input wire       I_FF_IS_SET,
  input wire       O_CFG_READY,
  input wire       O_DONE_OUT,
  input wire       O_DONE_OE_B,
  input wire       O_GLOBAL_OUTPUT_FLOAT,
  input wire       O_GLOBAL_SET_RESET,
  input wire       O_DONE_PULLUP,
  input wire       O_FF_FORCE,
  input wire       O_FF_VALUE,
  input wire       O_IO_HIZ,
  input wire       O_FINISHED,
  input wire [2:0] O_STEP
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);
  property p_od; O_DONE_OUT == 1'b0; endproperty
  a_od: assert property (p_od) else $error("completion pin driven high");
  property p_fin_hold; O_FINISHED |=> O_FINISHED; endproperty
  a_fin_hold: assert property (p_fin_hold) else $error("finished dropped");
  property p_fin_rel;
    O_FINISHED |-> O_DONE_OE_B && !O_GLOBAL_OUTPUT_FLOAT && !O_GLOBAL_SET_RESET;
  endproperty
  a_fin_rel: assert property (p_fin_rel) else $error("event held after finish");
  property p_step; O_STEP != $past(O_STEP) |-> O_STEP == $past(O_STEP) + 3'h1; endproperty
  a_step: assert property (p_step) else $error("step jumped");
  // Events change on the same core edge as the step
  property p_order;
    (O_STEP != 3'h0) |->
      O_DONE_OE_B == (O_STEP >= {1'b0, I_STEP_DONE}) &&
      O_GLOBAL_OUTPUT_FLOAT == (O_STEP < {1'b0, I_STEP_FLOAT}) &&
      O_GLOBAL_SET_RESET == (O_STEP < {1'b0, I_STEP_GSR});
  endproperty
  a_order: assert property (p_order) else $error("event order wrong");
  // Six cycles cover the pin synchroniser and the tick pipeline
  property p_stall;
    ((I_SU_OPTION[0] || I_EXPRESS) && O_DONE_OE_B && !I_DONE_PIN && !O_FINISHED) [*6]
      |=> $stable(O_STEP);
  endproperty
  a_stall: assert property (p_stall) else $error("advanced while net low");
  property p_gate;
    $fell(O_CFG_READY) |-> $past(I_MEM_FULL) && ($past(I_QUOTA_DONE) || !$past(I_EXPRESS));
  endproperty
  a_gate: assert property (p_gate) else $error("start without full load");
  // Three sync edges, one agree edge, then the ten-cycle master wait
  property p_master; $rose(O_CFG_READY) && I_MASTER |-> $past(I_INIT_B, 14); endproperty
  a_master: assert property (p_master) else $error("master wait too short");
  property p_pullup; $past(I_RST_B) |-> O_DONE_PULLUP == !$past(I_PULLUP_DIS); endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up control wrong");
  property p_ff;
    $past(I_RST_B) |->
      O_FF_FORCE == ($past(O_GLOBAL_SET_RESET) || $past(I_LOCAL_SET_RESET)) &&
      O_FF_VALUE == $past(I_FF_IS_SET);
  endproperty
  a_ff: assert property (p_ff) else $error("flop force wrong");
  property p_hiz;
    $past(I_RST_B) |-> O_IO_HIZ == ($past(O_GLOBAL_OUTPUT_FLOAT) && !$past(I_EXTEST));
  endproperty
  a_hiz: assert property (p_hiz) else $error("output float wrong");
endmodule // css_startup_chk

// ===== tb/css_done_net.sv
// Wired-AND completion net shared with the other chained devices
`timescale 1ns/100ps
module css_done_net (
  input  wire i_clk,
  input  wire i_oe_b,
  input  wire i_pullup,
  input  wire i_other_low,
  output reg  o_pin
);
  reg last_q = 1'b0;
  // Unpulled and undriven: inverse of last level, never a steady guess
  always @* begin
    if (!i_oe_b || i_other_low) o_pin = 1'b0;
    else if (i_pullup) o_pin = 1'b1;
    else o_pin = ~last_q;
  end
  always @(posedge i_clk) begin
    last_q <= o_pin;
  end
endmodule // css_done_net

// ===== tb/css_startup_tb.sv
// Testbench for the start-up sequencer
`timescale 1ns/100ps
module css_startup_tb;
  reg        clk = 0, rst_b = 0, init_b = 0, mst = 0, expr = 0, cp = 0, ll = 0, mf = 0;
  reg        qd = 0, osc = 0, usr = 0, ext = 0, lsr = 0, fs = 0, oth = 0, fin_q = 0, sync;
  reg [2:0]  mp = 0;
  reg [1:0]  opt = 0, sd = 0, sf = 0, sg = 0;
  reg [23:0] lv = 0;
  reg [31:0] rnd, rnd_n;
  reg        pud = 0;
  reg [9:0]  exp_q[$];
  wire [2:0] mode, step;
  wire       rdy, dout, oe_b, pu, gof, global_set_reset, fin, pin;
  integer    errors = 0, n_compared = 0, cyc = 0, seed = 32'h6cc2fd4b, k, j;
  always #5 clk = ~clk;
  // Start-up clocks are slow against the core, unrelated in phase
  always #80 osc = ~osc;
  always #55 usr = ~usr;
  css_startup #(.INIT_WAIT_CYC(10), .LEN_W(24)) i_css_startup (
    .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_INIT_B(init_b), .I_MODE_PINS(mp), .I_MASTER(mst),
    .I_EXPRESS(expr), .I_CFG_CLK_PULSE(cp), .I_LEN_LOAD(ll), .I_LEN_VALUE(lv), .I_MEM_FULL(mf),
    .I_QUOTA_DONE(qd), .I_SU_OPTION(opt), .I_PULLUP_DIS(pud), .I_STEP_DONE(sd),
    .I_STEP_FLOAT(sf), .I_STEP_GSR(sg), .I_CONFIG_OSC_CLOCK(osc), .I_USER_STARTUP_CLOCK(usr),
    .I_DONE_PIN(pin), .I_EXTEST(ext), .I_LOCAL_SET_RESET(lsr), .I_FF_IS_SET(fs), .O_MODE(mode),
    .O_CFG_READY(rdy), .O_DONE_OUT(dout), .O_DONE_OE_B(oe_b), .O_DONE_PULLUP(pu),
    .O_GLOBAL_OUTPUT_FLOAT(gof), .O_GLOBAL_SET_RESET(global_set_reset), .O_FF_FORCE(), .O_FF_VALUE(),
    .O_IO_HIZ(), .O_FINISHED(fin), .O_STEP(step));
  css_done_net i_css_done_net (.i_clk(clk), .i_oe_b(oe_b), .i_pullup(pu), .i_other_low(oth),
    .o_pin(pin));
  task cmp(input string what, input [9:0] e, input [9:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("mismatch %s expected %h seen %h", what, e, g);
      end
    end
  endtask
  task wrap_up;
    begin
      if (exp_q.size() != 0) errors = errors + 1;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task pulse;
    begin
      @(negedge clk) cp = 1;
      @(negedge clk) cp = 0;
    end
  endtask
  always @(negedge clk) begin
    rnd_n = $random(seed);
    {ext, lsr, fs} = rnd_n[2:0];
    // Pull-up only moves while the loading device still pulls the pin low
    pud = rnd_n[3] & (rdy === 1'b1);
    if (fin === 1'b1 && fin_q === 1'b0 && exp_q.size() > 0)
      cmp("final state", exp_q.pop_front(), {1'b0, mode, oe_b, gof, global_set_reset, step});
    fin_q = fin;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      wrap_up;
    end
  end
  initial begin
    for (k = 0; k < 8; k = k + 1) begin
      opt = k[1:0];
      expr = k[2];
      mst = k[0] ^ k[1];
      sync = opt[0] | expr;
      rnd = $random(seed);
      mp = rnd[2:0];
      rnd = $random(seed);
      {sd, sf, sg} = rnd[5:0];
      // First test keeps the default event order
      if (k == 0) {sd, sf, sg} = 6'h1b;
      rnd = $random(seed);
      lv = 24'h3 + {21'h0, rnd[2:0]};
      rst_b = 0; init_b = 0; mf = 0; qd = 0; oth = 0;
      repeat (6) @(negedge clk);
      rst_b = 1;
      repeat (2) @(negedge clk);
      init_b = 1;
      for (j = 0; j < 100 && rdy !== 1'b1; j = j + 1) @(negedge clk);
      if (!expr) begin
        ll = 1;
        @(negedge clk) ll = 0;
        mf = 1;
        repeat (lv - 1) pulse;
        repeat (3) @(negedge clk);
        cmp("ready short count", 10'h1, {9'h0, rdy});
        pulse;
      end else begin
        mf = 1;
        qd = 1;
      end
      exp_q.push_back({1'b0, mp, 1'b1, 1'b0, 1'b0, 3'h4});
      // Another device holds the net low; only sync options must wait
      oth = 1;
      repeat (300) @(negedge clk);
      cmp("finished while net held", {9'h0, ~sync}, {9'h0, fin});
      oth = 0;
      for (j = 0; j < 300 && fin !== 1'b1; j = j + 1) @(negedge clk);
      repeat (4) @(negedge clk);
      $display("test %0d done", k);
    end
    wrap_up;
  end
endmodule // css_startup_tb
bind css_startup css_startup_chk i_css_startup_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_B(I_RST_B),
  .I_INIT_B(I_INIT_B), .I_MASTER(I_MASTER), .I_EXPRESS(I_EXPRESS), .I_MEM_FULL(I_MEM_FULL),
  .I_QUOTA_DONE(I_QUOTA_DONE), .I_SU_OPTION(I_SU_OPTION), .I_STEP_DONE(I_STEP_DONE),
  .I_STEP_FLOAT(I_STEP_FLOAT), .I_STEP_GSR(I_STEP_GSR), .I_DONE_PIN(I_DONE_PIN),
  .I_PULLUP_DIS(I_PULLUP_DIS), .I_EXTEST(I_EXTEST), .I_LOCAL_SET_RESET(I_LOCAL_SET_RESET),
  .I_FF_IS_SET(I_FF_IS_SET), .O_DONE_PULLUP(O_DONE_PULLUP), .O_FF_FORCE(O_FF_FORCE),
  .O_FF_VALUE(O_FF_VALUE), .O_IO_HIZ(O_IO_HIZ),
  .O_CFG_READY(O_CFG_READY), .O_DONE_OUT(O_DONE_OUT), .O_DONE_OE_B(O_DONE_OE_B),
  .O_GLOBAL_OUTPUT_FLOAT(O_GLOBAL_OUTPUT_FLOAT), .O_GLOBAL_SET_RESET(O_GLOBAL_SET_RESET),
  .O_FINISHED(O_FINISHED), .O_STEP(O_STEP));
